/* File: verilog/sptd_map.svh */
`ifndef SPTD_MAP_SVH
`define SPTD_MAP_SVH

// Register addresses
`define SPTD_ADR_LOW_CLAMP 4'h1
`define SPTD_ADR_HIGH_CLAMP 4'h2
`define SPTD_ADR_QUIESCENT 4'h3
`define SPTD_ADR_GAIN 4'h4
`define SPTD_ADR_FILTER_RANGE 4'h5
`define SPTD_ADR_CUST_LOCK 4'h6
`define SPTD_ADR_CONV_RESULT 4'h7
`define SPTD_ADR_CONV_OFFSET 4'h8
`define SPTD_ADR_OSC_TRIM 4'h9
`define SPTD_ADR_LIN_TC 4'hB
`define SPTD_ADR_QUAD_TC 4'hC
`define SPTD_ADR_FACT_EXTRA 4'hD
`define SPTD_ADR_FACT_LOCK 4'hE

// Register widths
`define SPTD_W_LOW_CLAMP 4'hA
`define SPTD_W_HIGH_CLAMP 4'hB
`define SPTD_W_QUIESCENT 4'hB
`define SPTD_W_GAIN 4'hE
`define SPTD_W_FILTER_RANGE 4'h3
`define SPTD_W_LOCK 4'h1
`define SPTD_W_CONV_RESULT 4'hE
`define SPTD_W_CONV_OFFSET 4'h4
`define SPTD_W_OSC_TRIM 4'h5
`define SPTD_W_LIN_TC 4'h6
`define SPTD_W_QUAD_TC 4'h5
`define SPTD_W_FACT_EXTRA 4'h6
`define SPTD_W_NONE 4'h0
`define SPTD_DATA_BITS 4'hE

// Command codes
`define SPTD_CMD_READ 3'h2
`define SPTD_CMD_WRITE 3'h3
`define SPTD_CMD_PROGRAM 3'h4
`define SPTD_CMD_ERASE 3'h5
`define SPTD_CMD_FACT_LOCK 3'h6
`define SPTD_CMD_LOCK_ALL 3'h7

// Telegram shape
`define SPTD_HDR_BITS 5'h09
`define SPTD_WR_BITS 5'h18
`define SPTD_RD_ANS_BITS 5'h10
`define SPTD_ACK_BITS 5'h01

// Field layout of the left-aligned 24-bit telegram
`define SPTD_CMD_MSB 23
`define SPTD_CMD_LSB 21
`define SPTD_CP_POS 20
`define SPTD_ADR_MSB 19
`define SPTD_ADR_LSB 16
`define SPTD_AP_POS 15
`define SPTD_DAT_MSB 14
`define SPTD_DAT_LSB 1
`define SPTD_DP_POS 0
`define SPTD_HDR_PAD 15

// Parity masks
`define SPTD_MASK_CMD 14'h0007
`define SPTD_MASK_ADR 14'h000F
`define SPTD_MASK_DAT 14'h3FFF

// Timing
`define SPTD_CLK_NS 5
`define SPTD_OUT_BIT_NS 4000000
`define SPTD_OUT_MID_PCT 65
`define SPTD_SYNC_MAX_NS 7200000

// Resets
`define SPTD_RST_CNT 24'h000000
`define SPTD_RST_DATA14 14'h0000

`endif

/* File: verilog/sptd_pkg.sv */
package sptd_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_SYNC,
    RX_BIT,
    RX_DONE
  } sptd_rx_state_t;

  typedef enum logic {
    TX_IDLE,
    TX_BIT
  } sptd_tx_state_t;

endpackage : sptd_pkg

/* File: verilog/sptd_decoder.sv */
// Function
// - Sync bit length sets supply bit period
// - Three-bit command field selects operation
// - Command parity one when zeros odd
// - Four-bit address selects one register
// - Address parity one when zeros odd
// - Data field always fourteen bits
// - Write takes trailing register-width bits
// - Read places value in leading bits
// - Data parity one when zeros even
// - Codes 2 read, 3 write, 4 program
// - Code 5 erase, 6 factory lock
// - Code 7 locks device, analog only
// - Factory lock always set, never cleared
// - Multi-bit values sent MSB first
// - Sign-magnitude: leading bit is sign
// - Two's complement: leading bit negative
// - Factory trims readable, customer writes refused
// - Conversion result read-only, two's complement
// - Filter/range: upper bit corner, lower range
// - Writes go to RAM copy, govern operation
// - Erase then program; address ignored
// - Erase/program act on all registers
// - Linear TC sign-magnitude, quadratic unsigned
// - Bit ends with edge; mid edge means one
// - Valid write answered by single zero ack
// - Read answered by ack, data, parity
`include "sptd_map.svh"

module sptd_decoder
  import sptd_pkg::*;
#(
  parameter int OUT_BIT_CYC = `SPTD_OUT_BIT_NS / `SPTD_CLK_NS,
  parameter int SYNC_MAX_CYC = `SPTD_SYNC_MAX_NS / `SPTD_CLK_NS
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic supply_line_i,
  input wire logic [13:0] conversion_result_i,
  input wire logic [3:0] converter_offset_trim_i,
  input wire logic [4:0] oscillator_trim_i,
  input wire logic [5:0] factory_extra_settings_i,
  output logic answer_line_o,
  output logic answer_active_o,
  output logic [9:0] low_clamp_level_o,
  output logic [10:0] high_clamp_level_o,
  output logic [10:0] quiescent_output_level_o,
  output logic [13:0] gain_setting_o,
  output logic filter_corner_o,
  output logic [1:0] field_range_o,
  output logic [5:0] linear_temp_coeff_o,
  output logic [4:0] quadratic_temp_coeff_o,
  output logic customer_lock_flag_o,
  output logic factory_lock_flag_o,
  output logic analog_only_o,
  output logic eeprom_erase_o,
  output logic eeprom_program_o
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int OUT_MID_CYC = (OUT_BIT_CYC * `SPTD_OUT_MID_PCT) / 100;

  // Parity of zero count over the masked bits
  function automatic logic zeros_odd(input logic [13:0] v, input logic [13:0] mask);
    zeros_odd = ^(~v & mask);
  endfunction : zeros_odd

  function automatic logic [3:0] reg_width(input logic [3:0] adr);
    unique case (adr)
      `SPTD_ADR_LOW_CLAMP: reg_width = `SPTD_W_LOW_CLAMP;
      `SPTD_ADR_HIGH_CLAMP: reg_width = `SPTD_W_HIGH_CLAMP;
      `SPTD_ADR_QUIESCENT: reg_width = `SPTD_W_QUIESCENT;
      `SPTD_ADR_GAIN: reg_width = `SPTD_W_GAIN;
      `SPTD_ADR_FILTER_RANGE: reg_width = `SPTD_W_FILTER_RANGE;
      `SPTD_ADR_CUST_LOCK: reg_width = `SPTD_W_LOCK;
      `SPTD_ADR_CONV_RESULT: reg_width = `SPTD_W_CONV_RESULT;
      `SPTD_ADR_CONV_OFFSET: reg_width = `SPTD_W_CONV_OFFSET;
      `SPTD_ADR_OSC_TRIM: reg_width = `SPTD_W_OSC_TRIM;
      `SPTD_ADR_LIN_TC: reg_width = `SPTD_W_LIN_TC;
      `SPTD_ADR_QUAD_TC: reg_width = `SPTD_W_QUAD_TC;
      `SPTD_ADR_FACT_EXTRA: reg_width = `SPTD_W_FACT_EXTRA;
      `SPTD_ADR_FACT_LOCK: reg_width = `SPTD_W_LOCK;
      default: reg_width = `SPTD_W_NONE;
    endcase
  endfunction : reg_width

  // Supply line synchroniser
  logic line_meta_r;
  logic line_sync_r;
  logic line_prev_r;
  logic line_edge;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_meta_r <= 1'b0;
      line_sync_r <= 1'b0;
      line_prev_r <= 1'b0;
    end else begin
      line_meta_r <= supply_line_i;
      line_sync_r <= line_meta_r;
      line_prev_r <= line_sync_r;
    end
  end

  assign line_edge = line_sync_r ^ line_prev_r;

  // Receiver
  sptd_rx_state_t rx_state_r;
  logic [23:0] rx_cnt_r;
  logic [23:0] period_r;
  logic mid_seen_r;
  logic [23:0] shift_r;
  logic [4:0] nbits_r;
  logic [23:0] shift_nxt;
  logic [4:0] nbits_nxt;
  logic [23:0] mid_limit;
  logic [23:0] bit_timeout;

  assign shift_nxt = {shift_r[22:0], mid_seen_r};
  assign nbits_nxt = nbits_r + 5'h01;
  // Edges before 7/8 of a period are mid-bit edges; the 65% mid edge leaves margin
  assign mid_limit = period_r - (period_r >> 3);
  assign bit_timeout = period_r + (period_r >> 1);

  logic analog_only_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= `SPTD_RST_CNT;
      period_r <= `SPTD_RST_CNT;
      mid_seen_r <= 1'b0;
      shift_r <= `SPTD_RST_CNT;
      nbits_r <= 5'h00;
    end else begin
      unique case (rx_state_r)
        RX_IDLE: begin
          rx_cnt_r <= `SPTD_RST_CNT;
          // A locked device no longer listens
          if (line_edge && !analog_only_r) begin
            rx_state_r <= RX_SYNC;
          end
        end
        RX_SYNC: begin
          if (line_edge) begin
            period_r <= rx_cnt_r + 24'h000001;
            rx_cnt_r <= `SPTD_RST_CNT;
            mid_seen_r <= 1'b0;
            nbits_r <= 5'h00;
            shift_r <= `SPTD_RST_CNT;
            rx_state_r <= RX_BIT;
          end else if (rx_cnt_r >= 24'(SYNC_MAX_CYC)) begin
            rx_state_r <= RX_IDLE;
          end else begin
            rx_cnt_r <= rx_cnt_r + 24'h000001;
          end
        end
        RX_BIT: begin
          if (line_edge && rx_cnt_r < mid_limit) begin
            // Two mid edges cannot be a legal bit
            if (mid_seen_r) begin
              rx_state_r <= RX_IDLE;
            end
            mid_seen_r <= 1'b1;
            rx_cnt_r <= rx_cnt_r + 24'h000001;
          end else if (line_edge) begin
            shift_r <= shift_nxt;
            nbits_r <= nbits_nxt;
            mid_seen_r <= 1'b0;
            rx_cnt_r <= `SPTD_RST_CNT;
            if (nbits_nxt == `SPTD_HDR_BITS && shift_nxt[8:6] != `SPTD_CMD_WRITE) begin
              rx_state_r <= RX_DONE;
            end else if (nbits_nxt == `SPTD_WR_BITS) begin
              rx_state_r <= RX_DONE;
            end
          end else if (rx_cnt_r > bit_timeout) begin
            rx_state_r <= RX_IDLE;
          end else begin
            rx_cnt_r <= rx_cnt_r + 24'h000001;
          end
        end
        RX_DONE: begin
          rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Telegram fields, header-only telegrams padded to the write layout
  logic [23:0] tlg;
  logic [2:0] cmd;
  logic [3:0] adr;
  logic [13:0] dat;
  logic hdr_ok;
  logic dat_ok;
  logic is_write;
  logic exec_ok;

  assign tlg = (nbits_r == `SPTD_HDR_BITS) ? (shift_r << `SPTD_HDR_PAD) : shift_r;
  assign cmd = tlg[`SPTD_CMD_MSB:`SPTD_CMD_LSB];
  assign adr = tlg[`SPTD_ADR_MSB:`SPTD_ADR_LSB];
  assign dat = tlg[`SPTD_DAT_MSB:`SPTD_DAT_LSB];
  assign hdr_ok = (tlg[`SPTD_CP_POS] == zeros_odd({11'h000, cmd}, `SPTD_MASK_CMD))
    && (tlg[`SPTD_AP_POS] == zeros_odd({10'h000, adr}, `SPTD_MASK_ADR));
  assign dat_ok = tlg[`SPTD_DP_POS] == !zeros_odd(dat, `SPTD_MASK_DAT);
  assign is_write = cmd == `SPTD_CMD_WRITE;
  // Undefined codes 0 and 1 drop out here
  assign exec_ok = (rx_state_r == RX_DONE) && hdr_ok && (cmd >= `SPTD_CMD_READ)
    && (!is_write || dat_ok) && !analog_only_r;

  // RAM copies that govern the analog path
  logic [9:0] low_clamp_r;
  logic [10:0] high_clamp_r;
  logic [10:0] quiescent_r;
  logic [13:0] gain_r;
  logic [2:0] filter_range_r;
  logic [5:0] lin_tc_r;
  logic [4:0] quad_tc_r;
  logic cust_lock_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_clamp_r <= 10'h000;
      high_clamp_r <= 11'h000;
      quiescent_r <= 11'h000;
      gain_r <= `SPTD_RST_DATA14;
      filter_range_r <= 3'h0;
      lin_tc_r <= 6'h00;
      quad_tc_r <= 5'h00;
    end else if (exec_ok && is_write) begin
      // Factory, lock and result addresses fall through unchanged
      unique case (adr)
        `SPTD_ADR_LOW_CLAMP: low_clamp_r <= dat[9:0];
        `SPTD_ADR_HIGH_CLAMP: high_clamp_r <= dat[10:0];
        `SPTD_ADR_QUIESCENT: quiescent_r <= dat[10:0];
        `SPTD_ADR_GAIN: gain_r <= dat;
        `SPTD_ADR_FILTER_RANGE: filter_range_r <= dat[2:0];
        `SPTD_ADR_LIN_TC: lin_tc_r <= dat[5:0];
        `SPTD_ADR_QUAD_TC: quad_tc_r <= dat[4:0];
        default: begin
        end
      endcase
    end
  end

  // Lock: one-way, only the lock command sets it
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cust_lock_r <= 1'b0;
      analog_only_r <= 1'b0;
    end else if (exec_ok && cmd == `SPTD_CMD_LOCK_ALL) begin
      cust_lock_r <= 1'b1;
      analog_only_r <= 1'b1;
    end
  end

  // Nonvolatile strobes: whole array at once, address ignored
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eeprom_erase_o <= 1'b0;
      eeprom_program_o <= 1'b0;
    end else begin
      eeprom_erase_o <= exec_ok && cmd == `SPTD_CMD_ERASE;
      eeprom_program_o <= exec_ok && cmd == `SPTD_CMD_PROGRAM;
    end
  end

  // Read data, right-aligned, then moved to the leading bits
  logic [13:0] rd_val;
  logic [13:0] rd_field;

  always_comb begin
    unique case (adr)
      `SPTD_ADR_LOW_CLAMP: rd_val = {4'h0, low_clamp_r};
      `SPTD_ADR_HIGH_CLAMP: rd_val = {3'h0, high_clamp_r};
      `SPTD_ADR_QUIESCENT: rd_val = {3'h0, quiescent_r};
      `SPTD_ADR_GAIN: rd_val = gain_r;
      `SPTD_ADR_FILTER_RANGE: rd_val = {11'h000, filter_range_r};
      `SPTD_ADR_CUST_LOCK: rd_val = {13'h0000, cust_lock_r};
      `SPTD_ADR_CONV_RESULT: rd_val = conversion_result_i;
      `SPTD_ADR_CONV_OFFSET: rd_val = {10'h000, converter_offset_trim_i};
      `SPTD_ADR_OSC_TRIM: rd_val = {9'h000, oscillator_trim_i};
      `SPTD_ADR_LIN_TC: rd_val = {8'h00, lin_tc_r};
      `SPTD_ADR_QUAD_TC: rd_val = {9'h000, quad_tc_r};
      `SPTD_ADR_FACT_EXTRA: rd_val = {8'h00, factory_extra_settings_i};
      `SPTD_ADR_FACT_LOCK: rd_val = 14'h0001;
      default: rd_val = `SPTD_RST_DATA14;
    endcase
    rd_field = rd_val << (`SPTD_DATA_BITS - reg_width(adr));
  end

  // Answer transmitter, same edge coding as the supply line
  sptd_tx_state_t tx_state_r;
  logic [23:0] tx_cnt_r;
  logic [15:0] tx_bits_r;
  logic [4:0] tx_left_r;
  logic tx_line_r;
  logic tx_busy_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= `SPTD_RST_CNT;
      tx_bits_r <= 16'h0000;
      tx_left_r <= 5'h00;
      tx_line_r <= 1'b0;
      tx_busy_r <= 1'b0;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          // A telegram landing during an answer gets no answer
          if (exec_ok) begin
            tx_line_r <= !tx_line_r;
            tx_cnt_r <= `SPTD_RST_CNT;
            tx_state_r <= TX_BIT;
            tx_busy_r <= 1'b1;
            if (cmd == `SPTD_CMD_READ) begin
              tx_bits_r <= {1'b0, rd_field, !zeros_odd(rd_field, `SPTD_MASK_DAT)};
              tx_left_r <= `SPTD_RD_ANS_BITS;
            end else begin
              tx_bits_r <= 16'h0000;
              tx_left_r <= `SPTD_ACK_BITS;
            end
          end
        end
        TX_BIT: begin
          if (tx_cnt_r == 24'(OUT_BIT_CYC - 1)) begin
            tx_line_r <= !tx_line_r;
            tx_cnt_r <= `SPTD_RST_CNT;
            tx_bits_r <= {tx_bits_r[14:0], 1'b0};
            tx_left_r <= tx_left_r - 5'h01;
            if (tx_left_r == 5'h01) begin
              tx_state_r <= TX_IDLE;
              tx_busy_r <= 1'b0;
            end
          end else begin
            if (tx_cnt_r == 24'(OUT_MID_CYC) && tx_bits_r[15]) begin
              tx_line_r <= !tx_line_r;
            end
            tx_cnt_r <= tx_cnt_r + 24'h000001;
          end
        end
      endcase
    end
  end

  // Production lock is loaded by reset and rewritten to one on every cycle afterwards
  logic fact_lock_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fact_lock_r <= 1'b1;
    end else begin
      fact_lock_r <= 1'b1;
    end
  end

  assign answer_line_o = tx_line_r;
  assign answer_active_o = tx_busy_r;
  assign low_clamp_level_o = low_clamp_r;
  assign high_clamp_level_o = high_clamp_r;
  assign quiescent_output_level_o = quiescent_r;
  assign gain_setting_o = gain_r;
  assign filter_corner_o = filter_range_r[2];
  assign field_range_o = filter_range_r[1:0];
  assign linear_temp_coeff_o = lin_tc_r;
  assign quadratic_temp_coeff_o = quad_tc_r;
  assign customer_lock_flag_o = cust_lock_r;
  assign factory_lock_flag_o = fact_lock_r;
  assign analog_only_o = analog_only_r;

endmodule : sptd_decoder

/* File: sim/sptd_decoder_properties.sv */
`include "sptd_map.svh"

module sptd_decoder_checker #(
  parameter int OUT_BIT_CYC = `SPTD_OUT_BIT_NS / `SPTD_CLK_NS
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic supply_line_i,
  input wire logic answer_line_o,
  input wire logic answer_active_o,
  input wire logic [9:0] low_clamp_level_o,
  input wire logic [10:0] high_clamp_level_o,
  input wire logic [10:0] quiescent_output_level_o,
  input wire logic [13:0] gain_setting_o,
  input wire logic filter_corner_o,
  input wire logic [1:0] field_range_o,
  input wire logic [5:0] linear_temp_coeff_o,
  input wire logic [4:0] quadratic_temp_coeff_o,
  input wire logic customer_lock_flag_o,
  input wire logic factory_lock_flag_o,
  input wire logic analog_only_o,
  input wire logic eeprom_erase_o,
  input wire logic eeprom_program_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Counter trails the line by one, so the mid toggle shows one count late
  localparam int MID = OUT_BIT_CYC * `SPTD_OUT_MID_PCT / 100 + 1;
  int cnt_r;
  logic [59:0] ram_w;
  assign ram_w = {low_clamp_level_o, high_clamp_level_o, quiescent_output_level_o,
    gain_setting_o, filter_corner_o, field_range_o, linear_temp_coeff_o, quadratic_temp_coeff_o};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Cycles into the answer; keeps its last value on the closing cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_r <= 0;
    else if (answer_active_o) cnt_r <= cnt_r + 1;
    else cnt_r <= 0;
  end
  sequence ack_start; $rose(answer_active_o); endsequence
  sequence line_edge; $changed(answer_line_o); endsequence
  a_ack_start_edge: assert property (ack_start |-> line_edge)
    else $error("answer start without edge");
  a_ack_zero_bit: assert property (cnt_r > 0 && cnt_r < OUT_BIT_CYC |-> $stable(answer_line_o))
    else $error("ack bit not zero");
  a_bit_end_edge: assert property (cnt_r > 0 && cnt_r % OUT_BIT_CYC == 0 |-> line_edge)
    else $error("output bit without closing edge");
  a_no_stray_edge: assert property ((cnt_r % OUT_BIT_CYC != 0) &&
    (cnt_r % OUT_BIT_CYC != MID) |-> $stable(answer_line_o)) else $error("output edge off its slot");
  a_idle_quiet: assert property (!answer_active_o && cnt_r == 0 |-> $stable(answer_line_o))
    else $error("answer line moved while idle");
  a_answer_length: assert property ($fell(answer_active_o) |->
    cnt_r == OUT_BIT_CYC || cnt_r == 16 * OUT_BIT_CYC) else $error("bad answer length");
  a_reg_cause: assert property ($changed(ram_w) || eeprom_erase_o || eeprom_program_o
    |-> $past(supply_line_i, 3) != $past(supply_line_i, 6)) else $error("update without telegram");
  a_pulse_single: assert property (eeprom_erase_o || eeprom_program_o |=>
    !eeprom_erase_o && !eeprom_program_o) else $error("eeprom pulse too long");
  a_fact_lock_set: assert property (factory_lock_flag_o)
    else $error("factory lock cleared");
  a_lock_sticky: assert property (analog_only_o |=> analog_only_o && customer_lock_flag_o)
    else $error("device lock lost");
  a_locked_silent: assert property ($past(analog_only_o) |-> $stable(ram_w)
    && !eeprom_erase_o && !eeprom_program_o && !$rose(answer_active_o))
    else $error("locked device acted");
endmodule : sptd_decoder_checker

bind sptd_decoder sptd_decoder_checker #(.OUT_BIT_CYC(OUT_BIT_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .supply_line_i(supply_line_i),
  .answer_line_o(answer_line_o), .answer_active_o(answer_active_o),
  .low_clamp_level_o(low_clamp_level_o), .high_clamp_level_o(high_clamp_level_o),
  .quiescent_output_level_o(quiescent_output_level_o), .gain_setting_o(gain_setting_o),
  .filter_corner_o(filter_corner_o), .field_range_o(field_range_o),
  .linear_temp_coeff_o(linear_temp_coeff_o), .quadratic_temp_coeff_o(quadratic_temp_coeff_o),
  .customer_lock_flag_o(customer_lock_flag_o), .factory_lock_flag_o(factory_lock_flag_o),
  .analog_only_o(analog_only_o), .eeprom_erase_o(eeprom_erase_o),
  .eeprom_program_o(eeprom_program_o));

/* File: sim/sptd_prog_model.sv */
module sptd_prog_model #(
  parameter int PER = 40,
  parameter int OBIT = 40
) (
  input wire logic ref_clk_i,
  input wire logic answer_line_i,
  input wire logic answer_active_i,
  output logic supply_line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MID = PER * 13 / 20;
  initial supply_line_o = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  // Sync bit first; each following bit opens with the edge closing the last
  task automatic send(input logic [23:0] bits, input int n);
    supply_line_o = ~supply_line_o;
    tick(PER);
    for (int i = n - 1; i >= 0; i--) begin
      supply_line_o = ~supply_line_o;
      if (bits[i]) begin
        tick(MID);
        supply_line_o = ~supply_line_o;
        tick(PER - MID);
      end else begin
        tick(PER);
      end
    end
    supply_line_o = ~supply_line_o;
  endtask : send
  // Level seen early in a bit against late, so the closing edge never counts
  task automatic get(input int n, output logic [15:0] bits, output bit seen);
    logic lv;
    bits = 16'h0000;
    seen = 1'b0;
    for (int i = 0; i < 100 && !seen; i++) begin
      tick(1);
      seen = answer_active_i;
    end
    for (int i = n - 1; i >= 0 && seen; i--) begin
      tick(4);
      lv = answer_line_i;
      tick(OBIT * 4 / 5 - 4);
      bits[i] = answer_line_i !== lv;
      tick(OBIT - OBIT * 4 / 5);
    end
  endtask : get
endmodule : sptd_prog_model

/* File: sim/tb.sv */
`include "sptd_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OBIT = 40;
  localparam logic [3:0] RW_A [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hB, 4'hC};
  localparam int RW_W [7] = '{10, 11, 11, 14, 3, 6, 5};
  localparam logic [3:0] RO_A [5] = '{4'h7, 4'h8, 4'h9, 4'hD, 4'hE};
  localparam int RO_W [5] = '{14, 4, 5, 6, 1};
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [13:0] conv = 14'h2ABC;
  logic [3:0] offs = 4'h9;
  logic [4:0] osc = 5'h15;
  logic [5:0] extra = 6'h2D;
  wire logic sup, line, act, corner, clock, flock, analog, erase, prog;
  wire logic [9:0] lowc;
  wire logic [10:0] highc, quies;
  wire logic [13:0] gain;
  wire logic [1:0] range;
  wire logic [5:0] lintc;
  wire logic [4:0] quadtc;
  int errors = 0;
  int total_checks = 0;
  int n_erase = 0;
  int n_prog = 0;
  logic [15:0] ans;
  bit seen;
  logic [13:0] d, m;
  logic [13:0] ro_v [5];

  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (erase === 1'b1) n_erase++;
    if (prog === 1'b1) n_prog++;
  end

  sptd_decoder #(.OUT_BIT_CYC(OBIT), .SYNC_MAX_CYC(400)) i_dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .supply_line_i(sup),
    .conversion_result_i(conv), .converter_offset_trim_i(offs), .oscillator_trim_i(osc),
    .factory_extra_settings_i(extra), .answer_line_o(line), .answer_active_o(act),
    .low_clamp_level_o(lowc), .high_clamp_level_o(highc), .quiescent_output_level_o(quies),
    .gain_setting_o(gain), .filter_corner_o(corner), .field_range_o(range),
    .linear_temp_coeff_o(lintc), .quadratic_temp_coeff_o(quadtc),
    .customer_lock_flag_o(clock), .factory_lock_flag_o(flock), .analog_only_o(analog),
    .eeprom_erase_o(erase), .eeprom_program_o(prog));

  sptd_prog_model #(.PER(40), .OBIT(OBIT)) i_prog (
    .ref_clk_i(ref_clk_i), .answer_line_i(line), .answer_active_i(act), .supply_line_o(sup));

  function automatic logic [13:0] ram(input logic [3:0] a);
    case (a)
      4'h1: return 14'(lowc);
      4'h2: return 14'(highc);
      4'h3: return 14'(quies);
      4'h4: return gain;
      4'h5: return 14'({corner, range});
      4'hB: return 14'(lintc);
      4'hC: return 14'(quadtc);
      default: return 14'h0000;
    endcase
  endfunction : ram

  task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic tel(input logic [2:0] c, input logic [3:0] a, input logic [13:0] dat,
                     input logic [2:0] bad, input int n);
    logic [23:0] b;
    b = {c, ^(~c) ^ bad[2], a, ^(~a) ^ bad[1], dat, ~(^(~dat)) ^ bad[0]};
    if (c == `SPTD_CMD_WRITE) i_prog.send(b, 24);
    else i_prog.send(b >> 15, 9);
    i_prog.get(n, ans, seen);
    i_prog.tick(4);
  endtask : tel

  task automatic cmd(input logic [2:0] c, input logic [3:0] a, input logic [13:0] dat);
    tel(c, a, dat, 3'h0, 1);
    chk("ack", 16'({seen, ans[0]}), 16'h0002);
  endtask : cmd

  task automatic rd(input logic [3:0] a, input logic [13:0] v, input int w);
    logic [13:0] f;
    f = v << (14 - w);
    tel(`SPTD_CMD_READ, a, 14'h0000, 3'h0, 16);
    chk("read", ans, {1'b0, f, ~(^(~f))});
  endtask : rd

  task automatic end_sim();
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  initial begin
    repeat (90000) @(posedge ref_clk_i);
    errors++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1 arst_n_i = 1'b1;
    i_prog.tick(2);
    for (int a = 1; a < 13; a++) chk("reset", 16'(ram(4'(a))), 16'h0000);
    chk("flock", 16'(flock), 16'h0001);
    // Two patterns so stale or swapped bits cannot pass
    for (int p = 0; p < 2; p++) begin
      foreach (RW_A[i]) begin
        d = p ? 14'h2B6D : 14'h1492;
        m = 14'h3FFF >> (14 - RW_W[i]);
        cmd(`SPTD_CMD_WRITE, RW_A[i], d);
        chk("ram", 16'(ram(RW_A[i])), 16'(d & m));
        rd(RW_A[i], d & m, RW_W[i]);
      end
    end
    ro_v = '{conv, 14'(offs), 14'(osc), 14'(extra), 14'h0001};
    foreach (RO_A[i]) begin
      cmd(`SPTD_CMD_WRITE, RO_A[i], 14'h3FFF);
      rd(RO_A[i], ro_v[i], RO_W[i]);
    end
    // Live inputs must be read afresh, not latched once
    conv = 14'h1543;
    offs = 4'h6;
    rd(4'h7, conv, 14);
    rd(4'h8, 14'(offs), 4);
    cmd(`SPTD_CMD_WRITE, 4'h6, 14'h3FFF);
    chk("clock", 16'(clock), 16'h0000);
    rd(4'hA, 14'h0000, 14);
    // Bad parity on each field, then undefined codes
    for (int i = 0; i < 5; i++) begin
      tel(i < 3 ? 3'h3 : 3'(i - 3), 4'h1, 14'h0155, i < 3 ? 3'(1 << i) : 3'h0, 1);
      chk("silent", 16'(seen), 16'h0000);
      chk("kept", 16'(lowc), 16'(14'h2B6D & 14'h03FF));
    end
    cmd(`SPTD_CMD_ERASE, 4'hF, 14'h0000);
    cmd(`SPTD_CMD_PROGRAM, 4'h0, 14'h0000);
    cmd(`SPTD_CMD_FACT_LOCK, 4'h3, 14'h0000);
    chk("erase", 16'(n_erase), 16'h0001);
    chk("prog", 16'(n_prog), 16'h0001);
    chk("gain", 16'(gain), 16'(14'h2B6D));
    chk("flock", 16'(flock), 16'h0001);
    cmd(`SPTD_CMD_LOCK_ALL, 4'h1, 14'h0000);
    chk("locked", 16'({analog, clock}), 16'h0003);
    tel(`SPTD_CMD_WRITE, 4'h1, 14'h0000, 3'h0, 1);
    chk("locked wr", 16'({seen, lowc}), 16'(14'h2B6D & 14'h03FF));
    tel(`SPTD_CMD_READ, 4'h1, 14'h0000, 3'h0, 16);
    chk("locked rd", 16'(seen), 16'h0000);
    arst_n_i = 1'b0;
    i_prog.tick(2);
    arst_n_i = 1'b1;
    i_prog.tick(2);
    chk("rearm", 16'({analog, flock, lowc}), 16'h0400);
    end_sim();
  end
endmodule : tb
